// file: src/tmo_pkg.sv
// Package for the test-mode override block: register map, field layout,
// override encodings and reset values.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package tmo_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IN_OVR_OFS = 8'h08;
  localparam logic [7:0] OUT_OVR_OFS = 8'h0C;
  localparam logic [7:0] IN_STATE_OFS = 8'h10;
  localparam logic [7:0] OUT_STATE_OFS = 8'h14;

  // Control register field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  // Status register field positions
  localparam int STAT_ACTIVE_BIT = 0;

  // Width of one override selection field
  localparam int SEL_W = 2;

  // Input override selection codes; code 3 behaves as no override
  localparam logic [1:0] IN_SEL_NONE = 2'h0;
  localparam logic [1:0] IN_SEL_OPEN = 2'h1;
  localparam logic [1:0] IN_SEL_CLOSED = 2'h2;

  // Output override selection codes
  localparam logic [1:0] OUT_SEL_NONE = 2'h0;
  localparam logic [1:0] OUT_SEL_ENERGIZE = 2'h1;
  localparam logic [1:0] OUT_SEL_DEENERGIZE = 2'h2;
  localparam logic [1:0] OUT_SEL_FREEZE = 2'h3;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OVR_RST = 32'h0000_0000;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: src/test_mode_io_override.sv
// Test-mode override of contact inputs and contact outputs, with an
// AXI4-Lite register slave for the enable, trigger source and selections.
// Assumes one clock (aclk, 125 MHz) and a synchronous active-low reset;
// contact terminal levels arrive from pins, operands from on-chip logic.
`timescale 1ns/1ns

module test_mode_io_override
  import tmo_pkg::*;
#(
  parameter int N_IN = 8,   // Number of contact inputs
  parameter int N_OUT = 8   // Number of contact outputs
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address channel
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External test trigger operand, same clock domain
  input wire logic trigger_operand,
  // Sensed contact terminal levels, asynchronous pins
  input wire logic [N_IN-1:0] contact_sense,
  // Control operands of the contact outputs, same clock domain
  input wire logic [N_OUT-1:0] output_operand,
  // Reported contact input states toward protection logic
  output logic [N_IN-1:0] input_report,
  // Contact drive, 1 closes the contact
  output logic [N_OUT-1:0] contact_close,
  // Test-mode indicator
  output logic test_indicator
);

  // Each selection bank must fit in one 32-bit register
  if (N_IN < 1 || N_IN * SEL_W > 32) begin : gen_bad_n_in
    $error("N_IN must be 1 to 16");
  end
  if (N_OUT < 1 || N_OUT * SEL_W > 32) begin : gen_bad_n_out
    $error("N_OUT must be 1 to 16");
  end

  localparam int IN_W = N_IN * SEL_W;
  localparam int OUT_W = N_OUT * SEL_W;

  // Software-visible settings
  logic test_enable_r;     // Test function enabled
  logic trigger_src_r;     // 0: always on, 1: external operand
  logic [IN_W-1:0] input_override_select;   // Per-input selections
  logic [OUT_W-1:0] output_override_select; // Per-output selections

  // Test-mode state
  logic test_active_r;     // Test mode in force
  logic test_nxt;          // Test mode condition this cycle
  logic [N_OUT-1:0] frozen_r; // Output states caught on entry

  // Two-flop synchroniser for terminal levels
  logic [N_IN-1:0] sense_meta_r;
  logic [N_IN-1:0] sense_sync_r;

  // Bus slave state
  logic aw_held_r;         // Write address captured
  logic w_held_r;          // Write data captured
  logic [7:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // Apply byte strobes to a 32-bit register value
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

  // True when the byte address names a mapped register
  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == CTRL_OFS || addr == STATUS_OFS || addr == IN_OVR_OFS
      || addr == OUT_OVR_OFS || addr == IN_STATE_OFS
      || addr == OUT_STATE_OFS;
  endfunction

  // ---------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------

  // Address and data are taken independently; the response waits
  // for both, so the master may present them in either order.
  wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      waddr_r <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      waddr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
      s_axi_awready <= 1'b0;
    end else begin
      // Ready only while no address waits, one write at a time
      s_axi_awready <= !aw_held_r && !s_axi_bvalid;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held_r <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_r && !s_axi_bvalid;
    end
  end

  // Write response; unmapped or read-only offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (waddr_r == CTRL_OFS || waddr_r == IN_OVR_OFS
          || waddr_r == OUT_OVR_OFS) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Merged words are formed outside the flops, so the clocked
  // processes hold only non-blocking updates
  logic [31:0] ctrl_merged;     // Control word after byte merge
  logic [31:0] in_ovr_merged;   // Input selections after byte merge
  logic [31:0] out_ovr_merged;  // Output selections after byte merge
  assign ctrl_merged = merge_bytes({30'h0, trigger_src_r, test_enable_r},
    wdata_r, wstrb_r);
  assign in_ovr_merged = merge_bytes(32'(input_override_select), wdata_r,
    wstrb_r);
  assign out_ovr_merged = merge_bytes(32'(output_override_select),
    wdata_r, wstrb_r);

  // Control register: enable and trigger source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_enable_r <= CTRL_RST[CTRL_EN_BIT];
      trigger_src_r <= CTRL_RST[CTRL_SRC_BIT];
    end else if (do_write && waddr_r == CTRL_OFS) begin
      test_enable_r <= ctrl_merged[CTRL_EN_BIT];
      trigger_src_r <= ctrl_merged[CTRL_SRC_BIT];
    end
  end

  // Per-contact override selections, one field per contact
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_override_select <= OVR_RST[IN_W-1:0];
      output_override_select <= OVR_RST[OUT_W-1:0];
    end else if (do_write) begin
      if (waddr_r == IN_OVR_OFS) begin
        input_override_select <= in_ovr_merged[IN_W-1:0];
      end
      if (waddr_r == OUT_OVR_OFS) begin
        output_override_select <= out_ovr_merged[OUT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Read data mux; reserved bits read as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      CTRL_OFS: begin
        rd_mux[CTRL_EN_BIT] = test_enable_r;
        rd_mux[CTRL_SRC_BIT] = trigger_src_r;
      end
      STATUS_OFS: rd_mux[STAT_ACTIVE_BIT] = test_active_r;
      IN_OVR_OFS: rd_mux = 32'(input_override_select);
      OUT_OVR_OFS: rd_mux = 32'(output_override_select);
      IN_STATE_OFS: rd_mux = 32'(input_report);
      OUT_STATE_OFS: rd_mux = 32'(contact_close);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read channel: one read at a time, answered the cycle after take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Test-mode control
  // ---------------------------------------------------------------

  // Trigger is the constant 'on' or the external operand
  assign test_nxt = test_enable_r
    && (trigger_src_r ? trigger_operand : 1'b1);

  // Test-mode state and its indicator move together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_active_r <= 1'b0;
      test_indicator <= 1'b0;
    end else begin
      test_active_r <= test_nxt;
      test_indicator <= test_nxt;
    end
  end

  // Catch output states on the entry edge only; the drive register
  // still holds the pre-test value at that edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frozen_r <= '0;
    end else if (test_nxt && !test_active_r) begin
      frozen_r <= contact_close;
    end
  end

  // ---------------------------------------------------------------
  // Contact inputs
  // ---------------------------------------------------------------

  // Terminal levels are asynchronous; only the second flop is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_meta_r <= '0;
      sense_sync_r <= '0;
    end else begin
      sense_meta_r <= contact_sense;
      sense_sync_r <= sense_meta_r;
    end
  end

  // Reported state: sensed level unless forced during test mode.
  // Only contact logic looks at test mode; all else runs as normal.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_report <= '0;
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        if (!test_active_r) begin
          input_report[i] <= sense_sync_r[i];
        end else begin
          unique case (input_override_select[SEL_W*i +: SEL_W])
            IN_SEL_OPEN: input_report[i] <= 1'b0;
            IN_SEL_CLOSED: input_report[i] <= 1'b1;
            // No override, and unused code 3, follow the terminals
            default: input_report[i] <= sense_sync_r[i];
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Contact outputs
  // ---------------------------------------------------------------

  // Drive follows the operand outside test mode and when unforced
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      contact_close <= '0;
    end else begin
      for (int o = 0; o < N_OUT; o++) begin
        if (!test_nxt) begin
          contact_close[o] <= output_operand[o];
        end else begin
          unique case (output_override_select[SEL_W*o +: SEL_W])
            OUT_SEL_NONE: contact_close[o] <= output_operand[o];
            OUT_SEL_ENERGIZE: contact_close[o] <= 1'b1;
            OUT_SEL_DEENERGIZE: contact_close[o] <= 1'b0;
            OUT_SEL_FREEZE: begin
              // On the entry cycle frozen_r is not loaded yet
              contact_close[o] <= test_active_r ? frozen_r[o]
                : contact_close[o];
            end
          endcase
        end
      end
    end
  end

endmodule

// file: tb/tmo_props.sv
// Checker for the test-mode override block: bus timing, contact paths.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module tmo_props
  import tmo_pkg::*;
#(
  parameter int N_IN = 8,
  parameter int N_OUT = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N_IN-1:0] contact_sense,
  input wire logic [N_OUT-1:0] output_operand,
  input wire logic [N_IN-1:0] input_report,
  input wire logic [N_OUT-1:0] contact_close,
  input wire logic test_indicator
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Edges since reset release; the input sync path needs three
  logic [1:0] live_r;
  // Saturating count, so old sense samples are never compared
  always_ff @(posedge aclk) begin
    if (!aresetn) live_r <= 2'h0;
    else if (live_r != 2'h3) live_r <= live_r + 2'h1;
  end
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  chk_aw_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write ready too soon");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready too soon");
  chk_aw_back: assert property (s_axi_bvalid && s_axi_bready |->
    ##[1:3] s_axi_awready && s_axi_wready) else $error("write stuck");
  chk_ar_back: assert property (s_axi_rvalid && s_axi_rready |->
    ##[1:3] s_axi_arready) else $error("read stuck");
  chk_err_data: assert property (s_axi_rvalid &&
    s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read not zero");
  chk_out_follow: assert property (
    $past(aresetn) && !test_indicator |->
    contact_close == $past(output_operand)) else $error("drive wrong");
  chk_in_follow: assert property (
    live_r == 2'h3 && !test_indicator && !$past(test_indicator) |->
    input_report == $past(contact_sense, 3)) else $error("report wrong");
endmodule

bind test_mode_io_override tmo_props #(.N_IN(N_IN), .N_OUT(N_OUT))
  tmo_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .contact_sense, .output_operand,
  .input_report, .contact_close, .test_indicator);

// file: tb/field_wiring.sv
// Field side of the contacts: terminal levels seen by the inputs.
// Assumes the bench picks either free levels or a loopback jig.
`timescale 1ns/1ns
module field_wiring #(
  parameter int N = 8
) (
  input wire logic [N-1:0] contact_close,
  input wire logic loop_en,
  input wire logic [N-1:0] field_level,
  output logic [N-1:0] contact_sense
);
  // Loopback wires each output contact onto the matching input
  assign contact_sense = loop_en ? contact_close : field_level;
endmodule

// file: tb/tb_test_mode_io_override.sv
// Bench for the test-mode override block: register bus and contacts.
// Assumes 8 inputs and 8 outputs; field wiring model on the far side.
`timescale 1ns/1ns
module tb_test_mode_io_override
  import tmo_pkg::*;
  ;
  typedef struct {
    logic [1:0] ctrl;
    logic trig;
    logic [7:0] sense, oper, rep, close;
    logic ind;
  } row_s;
  logic aclk = '0, aresetn = '0, loop_en = '0, trigger_operand = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [7:0] field_level = '0, output_operand = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic [2:0] prot = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, test_indicator;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] contact_sense, input_report, contact_close;
  int errors = 0;
  int cmp_count = 0;
  // Selections E4E4: per contact codes 0,1,2,3 repeated
  row_s rows [6] = '{
    '{2'h0, 1'h0, 8'hA5, 8'h3C, 8'hA5, 8'h3C, 1'h0},
    '{2'h1, 1'h0, 8'hA5, 8'hC3, 8'hC5, 8'h2B, 1'h1},
    '{2'h3, 1'h0, 8'h5A, 8'h96, 8'h5A, 8'h96, 1'h0},
    '{2'h3, 1'h1, 8'h5A, 8'h69, 8'h5C, 8'hA3, 1'h1},
    '{2'h3, 1'h0, 8'hFF, 8'h00, 8'hFF, 8'h00, 1'h0},
    '{2'h2, 1'h1, 8'h00, 8'hFF, 8'h00, 8'hFF, 1'h0}};

  always #4 aclk = ~aclk;

  test_mode_io_override test_mode_io_override_inst (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot(prot), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(prot), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_operand,
    .contact_sense, .output_operand, .input_report, .contact_close,
    .test_indicator);
  field_wiring field_wiring_inst (.contact_close, .loop_en, .field_level,
    .contact_sense);

  // Verdict and end of run
  task automatic conclude;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Value compare; case inequality so unknowns fail
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // A bus wait that ran out counts once and ends the run
  task automatic stuck(string nm, bit done);
    if (!done) begin
      errors++;
      $display("CHECK FAILED %s wait exp answer got none", nm);
      conclude();
    end
  endtask
  // Write: AW and W offered together, each dropped when taken.
  // bready is lowered by non-blocking assignment so the slave still
  // sees it high at the edge where bvalid is consumed.
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s,
    logic [1:0] er);
    int n = 0;
    bit done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done && n < 60) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'h0;
        done = 1'b1;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
      end
    end
    stuck("write", done);
  endtask
  // Read: address held until taken, data taken with rvalid
  task automatic rd(string nm, logic [7:0] a, logic [31:0] e,
    logic [1:0] er);
    int n = 0;
    bit done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done && n < 60) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'h0;
        done = 1'b1;
        chk(nm, e, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
      end
    end
    stuck(nm, done);
  endtask

  // Main sequence: reset, table of steady states, then odd cases
  initial begin
    repeat (5) @(posedge aclk);
    chk("reset outs", 32'h0, 32'({input_report, contact_close,
      test_indicator}));
    aresetn <= 1'h1;
    rd("ctrl", CTRL_OFS, CTRL_RST, RESP_OKAY);
    rd("in_ovr", IN_OVR_OFS, OVR_RST, RESP_OKAY);
    rd("out_ovr", OUT_OVR_OFS, OVR_RST, RESP_OKAY);
    wr(IN_OVR_OFS, 32'h0000_E4E4, 4'hF, RESP_OKAY);
    wr(OUT_OVR_OFS, 32'h0000_E4E4, 4'hF, RESP_OKAY);
    foreach (rows[i]) begin
      wr(CTRL_OFS, {30'h0, rows[i].ctrl}, 4'hF, RESP_OKAY);
      trigger_operand <= rows[i].trig;
      field_level <= rows[i].sense;
      output_operand <= rows[i].oper;
      repeat (5) @(posedge aclk);
      chk("input_report", 32'(rows[i].rep), 32'(input_report));
      chk("contact_close", 32'(rows[i].close), 32'(contact_close));
      chk("indicator", 32'(rows[i].ind), 32'(test_indicator));
      rd("status", STATUS_OFS, 32'(rows[i].ind), RESP_OKAY);
      rd("in_state", IN_STATE_OFS, 32'(rows[i].rep), RESP_OKAY);
      rd("out_state", OUT_STATE_OFS, 32'(rows[i].close), RESP_OKAY);
    end
    // Refused accesses leave the registers alone
    rd("unmapped", 8'h20, 32'h0, RESP_SLVERR);
    wr(STATUS_OFS, 32'h1, 4'hF, RESP_SLVERR);
    wr(8'h40, 32'h1, 4'hF, RESP_SLVERR);
    rd("ctrl kept", CTRL_OFS, 32'h2, RESP_OKAY);
    wr(IN_OVR_OFS, 32'h0, 4'h2, RESP_OKAY);
    rd("in_ovr strb", IN_OVR_OFS, 32'hE4, RESP_OKAY);
    // Loopback jig in test with every selection back to none
    wr(IN_OVR_OFS, 32'h0, 4'hF, RESP_OKAY);
    wr(OUT_OVR_OFS, 32'h0, 4'hF, RESP_OKAY);
    wr(CTRL_OFS, 32'h1, 4'hF, RESP_OKAY);
    loop_en <= 1'h1;
    output_operand <= 8'h5A;
    repeat (6) @(posedge aclk);
    chk("indicator", 32'h1, 32'(test_indicator));
    chk("contact_close", 32'h5A, 32'(contact_close));
    chk("input_report", 32'h5A, 32'(input_report));
    // Reset in mid-run, in test mode: outputs and settings clear
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("mid reset outs", 32'h0, 32'({input_report, contact_close,
      test_indicator}));
    aresetn <= 1'h1;
    rd("ctrl after reset", CTRL_OFS, CTRL_RST, RESP_OKAY);
    rd("status after reset", STATUS_OFS, 32'h0, RESP_OKAY);
    chk("contact_close", 32'h5A, 32'(contact_close));
    chk("input_report", 32'h5A, 32'(input_report));
    conclude();
  end
endmodule
